// ---- rtl/swwc_pkg.sv ----
// constants and types for the sleep, wake and watchdog controller
// ----------------------------------------------------------------
// Notes on behaviour
// - fuse off, clear, osc fail, fast wake clear watchdog
// - crystal wake holds watchdog cleared through start-up
// - start-up 1024 periods crystal only, else skipped
// - sleep clears watchdog, which keeps counting asleep
// - sleep entry clears powerdown, sets timeout flag
// - asleep: oscillator driver off, I/O states held
// - watchdog reset never pulls master clear low
// - pin wake resets; watchdog/interrupt wake resumes
// - watchdog wake clears the timeout flag
// - powerdown flag set at power-up, cleared sleeping
// - only six listed interrupt sources can wake
// - sleep execution prefetches the next address
// - enabled interrupt wakes regardless of global enable
// - global enable set: prefetched then vector 0004h
// - global off, enabled flagged source: resume, no vector jump
// - every wake from sleep clears the watchdog
// - pending enabled interrupt makes sleep a no-operation
// - interrupt after sleep: sleep effects then wake
// - expiry resets when running, wakes when sleeping
// - option register assigns prescaler up to 1:128
// - clear or sleep also clears assigned prescaler
// ----------------------------------------------------------------
package swwc_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int WDT_PERIOD_NS = 18_000_000;
  localparam int WDT_CYCLES = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OST_TOSC = 1024;
  localparam int TOSC_NS = CLK_PERIOD_NS;
  localparam int OST_CYCLES =
    (OST_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [13:0] IRQ_VECTOR = 14'h0004;
  // register byte addresses
  localparam logic [7:0] ADDR_OPTION = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // reset values
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  // field positions
  localparam int OPT_PSA = 3;
  localparam int OPT_PS_LSB = 0;
  localparam int CFG_WATCHDOG_ENABLE_FUSE = 3;
  localparam int CFG_FOSC_LSB = 0;
  localparam int STAT_TO = 0;
  localparam int STAT_PD = 1;
  localparam int STAT_SLEEP = 2;
  localparam int STAT_CAUSE_LSB = 4;
  // oscillator mode codes in the configuration word
  localparam logic [2:0] FOSC_LP = 3'h0;
  localparam logic [2:0] FOSC_XT = 3'h1;
  localparam logic [2:0] FOSC_HS = 3'h2;
  // wake sources: t1 async, capture, adc rc, comparator, ioc, int pin
  localparam int NUM_WAKE = 6;
  // wake cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_MASTER_CLEAR_PIN = 2'h1;
  localparam logic [1:0] CAUSE_WDT = 2'h2;
  localparam logic [1:0] CAUSE_IRQ = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SWWC_RUN = 2'b00,
    SWWC_SLEEP = 2'b01,
    SWWC_OST = 2'b10,
    SWWC_WAKE = 2'b11
  } swwc_state_t;
endpackage : swwc_pkg

// ---- rtl/swwc_top.sv ----
// sleep entry, wake-up and watchdog control with an axi4-lite slave
module swwc_top #(
  parameter int WDT_CYCLES = swwc_pkg::WDT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fuses and core events
  input wire logic [7:0] configuration_word,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic global_irq_enable,
  input wire logic [5:0] irq_enable,
  input wire logic [5:0] irq_flag,
  input wire logic osc_fail,
  // master clear pin, open drain
  input wire logic master_clear_pin_n_i,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe_n,
  // decisions to the core
  output logic device_reset,
  output logic prefetch_next,
  output logic resume_exec,
  output logic vector_branch,
  output logic [13:0] vector_addr,
  output logic osc_driver_en,
  output logic io_hold,
  output logic sleeping,
  output logic powerdown_flag,
  output logic timeout_flag
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    swwc_pkg::swwc_state_t st; // sequencer state
    logic [7:0] option; // option_control
    logic [22:0] wdt; // watchdog counter
    logic [6:0] psc; // shared prescaler
    logic [10:0] oscillator_startup_timer; // start-up counter
    logic pd; // powerdown flag
    logic to; // timeout flag
    logic [1:0] cause; // last wake cause
    logic [2:0] master_clear_pin_s; // pin synchroniser
    logic master_clear_pin_low; // filtered pin level
    logic rst_out; // device reset pulse
    logic pref; // prefetch pulse
    logic resume; // resume pulse
    logic vec; // vector branch pulse
    logic osc_en; // oscillator driver enable
    logic hold; // io hold
    logic slp; // registered sleeping level
    logic aw_have; // write address held
    logic w_have; // write data held
    logic [7:0] awaddr; // latched write address
    logic [31:0] wdata; // latched write data
    logic wstrb0; // latched lane 0 strobe
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } swwc_state_rec_t;

  swwc_state_rec_t q, d;

  // crystal modes need the start-up timer
  function automatic logic swwc_is_crystal(input logic [2:0] fosc);
    swwc_is_crystal = (fosc == swwc_pkg::FOSC_LP) ||
                      (fosc == swwc_pkg::FOSC_XT) ||
                      (fosc == swwc_pkg::FOSC_HS);
  endfunction : swwc_is_crystal

  // address decode shared by read and write paths
  function automatic logic [1:0] swwc_decode(input logic [7:0] addr);
    swwc_decode = 2'h3;
    if (addr == swwc_pkg::ADDR_OPTION) begin
      swwc_decode = 2'h0;
    end else if (addr == swwc_pkg::ADDR_CONFIG) begin
      swwc_decode = 2'h1;
    end else if (addr == swwc_pkg::ADDR_STATUS) begin
      swwc_decode = 2'h2;
    end
  endfunction : swwc_decode

  // ----------------------------------------------------------------
  // derived terms
  // ----------------------------------------------------------------
  logic watchdog_enable_fuse; // watchdog fuse
  logic crystal; // crystal oscillator mode
  logic prescaler_assign; // prescaler to watchdog
  logic [2:0] ps; // ratio select
  logic [6:0] psc_mask; // prescaler terminal mask
  logic wdt_tick; // counter advance
  logic wdt_expire; // counter terminal
  logic irq_pending; // enabled and flagged source
  logic [31:0] status_word; // status readback

  always_comb begin
    watchdog_enable_fuse = configuration_word[swwc_pkg::CFG_WATCHDOG_ENABLE_FUSE];
    crystal = swwc_is_crystal(
      configuration_word[swwc_pkg::CFG_FOSC_LSB +: 3]);
    prescaler_assign = q.option[swwc_pkg::OPT_PSA];
    ps = q.option[swwc_pkg::OPT_PS_LSB +: 3];
    psc_mask = 7'((8'h01 << ps) - 8'h01);
    wdt_tick = prescaler_assign ? ((q.psc & psc_mask) == psc_mask) : 1'b1;
    wdt_expire = watchdog_enable_fuse && wdt_tick &&
                 (q.wdt == 23'(WDT_CYCLES - 1));
    irq_pending = |(irq_enable & irq_flag);
    status_word = 32'h0000_0000;
    status_word[swwc_pkg::STAT_TO] = q.to;
    status_word[swwc_pkg::STAT_PD] = q.pd;
    status_word[swwc_pkg::STAT_SLEEP] = (q.st != swwc_pkg::SWWC_RUN);
    status_word[swwc_pkg::STAT_CAUSE_LSB +: 2] = q.cause;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wdt_clr; // watchdog clear request
    logic psc_clr; // prescaler clear request
    logic aw_hs; // address taken
    logic w_hs; // data taken
    logic ar_hs; // read address taken
    wdt_clr = 1'b0;
    psc_clr = 1'b0;
    aw_hs = s_axi_awvalid && q.awready;
    w_hs = s_axi_wvalid && q.wready;
    ar_hs = s_axi_arvalid && q.arready;
    d = q;
    // one-cycle pulses drop by default
    d.rst_out = 1'b0;
    d.pref = 1'b0;
    d.resume = 1'b0;
    d.vec = 1'b0;

    // three-stage pin sync, level updates when the last two stages agree
    d.master_clear_pin_s = {q.master_clear_pin_s[1:0], master_clear_pin_n_i};
    if (q.master_clear_pin_s[1] == q.master_clear_pin_s[2]) begin
      d.master_clear_pin_low = !q.master_clear_pin_s[2];
    end

    // free-running prescaler
    d.psc = 7'(q.psc + 7'h01);
    // watchdog advances on prescaler terminal when assigned, else every cycle
    if (wdt_tick) begin
      d.wdt = 23'(q.wdt + 23'h000001);
    end

    if (!watchdog_enable_fuse || watchdog_clear_instr || osc_fail) begin
      wdt_clr = 1'b1;
    end
    if (watchdog_clear_instr) begin
      psc_clr = 1'b1;
    end

    // sequencer
    unique case (q.st)
      swwc_pkg::SWWC_RUN: begin
        if (sleep_instr) begin
          d.pref = 1'b1;
          if (!irq_pending) begin
            wdt_clr = 1'b1;
            psc_clr = 1'b1;
            d.pd = 1'b0;
            d.to = 1'b1;
            d.osc_en = 1'b0;
            d.hold = 1'b1;
            d.st = swwc_pkg::SWWC_SLEEP;
          end
        end else if (wdt_expire) begin
          d.rst_out = 1'b1;
          d.to = 1'b0;
          d.option = swwc_pkg::OPTION_RESET;
          wdt_clr = 1'b1;
          psc_clr = 1'b1;
        end
      end
      swwc_pkg::SWWC_SLEEP: begin
        if (wdt_expire) begin
          d.to = 1'b0;
          d.cause = swwc_pkg::CAUSE_WDT;
          d.st = crystal ? swwc_pkg::SWWC_OST : swwc_pkg::SWWC_WAKE;
          d.oscillator_startup_timer = '0;
          wdt_clr = 1'b1;
        end else if (irq_pending) begin
          d.cause = swwc_pkg::CAUSE_IRQ;
          d.st = crystal ? swwc_pkg::SWWC_OST : swwc_pkg::SWWC_WAKE;
          d.oscillator_startup_timer = '0;
          wdt_clr = 1'b1;
        end
        if (d.st != swwc_pkg::SWWC_SLEEP) begin
          d.osc_en = 1'b1;
        end
      end
      swwc_pkg::SWWC_OST: begin
        wdt_clr = 1'b1;
        d.oscillator_startup_timer = 11'(q.oscillator_startup_timer + 11'h001);
        if (q.oscillator_startup_timer == 11'(swwc_pkg::OST_CYCLES - 1)) begin
          d.st = swwc_pkg::SWWC_WAKE;
        end
      end
      swwc_pkg::SWWC_WAKE: begin
        wdt_clr = 1'b1;
        d.resume = 1'b1;
        d.vec = (q.cause == swwc_pkg::CAUSE_IRQ) && global_irq_enable;
        d.hold = 1'b0;
        d.st = swwc_pkg::SWWC_RUN;
      end
    endcase

    // master clear pin gives full reset
    if (q.master_clear_pin_low) begin
      d.rst_out = 1'b1;
      d.option = swwc_pkg::OPTION_RESET;
      d.osc_en = 1'b1;
      d.hold = 1'b0;
      if (q.st != swwc_pkg::SWWC_RUN) begin
        d.cause = swwc_pkg::CAUSE_MASTER_CLEAR_PIN;
      end
      d.st = swwc_pkg::SWWC_RUN;
      wdt_clr = 1'b1;
      psc_clr = 1'b1;
    end

    // sleeping level registered so the port comes from a flop
    d.slp = (d.st != swwc_pkg::SWWC_RUN);

    if (wdt_clr) begin
      d.wdt = '0;
    end
    if (psc_clr && prescaler_assign) begin
      d.psc = '0;
    end

    // ----------------------------------------------------------------
    // write channel: address and data in either order
    // ----------------------------------------------------------------
    if (aw_hs) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = swwc_pkg::RESP_OKAY;
      unique case (swwc_decode(q.awaddr))
        2'h0: begin
          if (q.wstrb0 && !q.master_clear_pin_low && !d.rst_out) begin
            d.option = q.wdata[7:0];
          end
        end
        2'h1, 2'h2: begin
          // read-only, write ignored
        end
        2'h3: begin
          d.bresp = swwc_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_have;
    d.wready = !d.w_have;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp = swwc_pkg::RESP_OKAY;
      unique case (swwc_decode(s_axi_araddr))
        2'h0: begin
          d.rdata = {24'h000000, q.option};
        end
        2'h1: begin
          d.rdata = {24'h000000, configuration_word};
        end
        2'h2: begin
          d.rdata = status_word;
        end
        2'h3: begin
          d.rdata = 32'h0000_0000;
          d.rresp = swwc_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.arready = !d.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= swwc_pkg::SWWC_RUN;
      q.option <= swwc_pkg::OPTION_RESET;
      q.pd <= 1'b1;
      q.to <= 1'b1;
      q.master_clear_pin_s <= 3'h7;
      q.osc_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register except the constant vector_addr
  // ----------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // pin never driven by this block
  assign master_clear_pin_o = q.master_clear_pin_s[2] & 1'b0;
  assign master_clear_pin_oe_n = !q.rst_out | 1'b1;
  assign device_reset = q.rst_out;
  assign prefetch_next = q.pref;
  assign resume_exec = q.resume;
  assign vector_branch = q.vec;
  assign vector_addr = swwc_pkg::IRQ_VECTOR;
  assign osc_driver_en = q.osc_en;
  assign io_hold = q.hold;
  assign sleeping = q.slp;
  assign powerdown_flag = q.pd;
  assign timeout_flag = q.to;

endmodule : swwc_top

// ---- tb/swwc_chk.sv ----
// checker of sleep, wake and watchdog behaviour at the top ports
module swwc_chk #(
  parameter int WDT_CYCLES = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] configuration_word,
  input wire logic sleep_instr,
  input wire logic [5:0] irq_enable,
  input wire logic [5:0] irq_flag,
  input wire logic master_clear_pin_n_i,
  input wire logic master_clear_pin_oe_n,
  input wire logic device_reset,
  input wire logic prefetch_next,
  input wire logic resume_exec,
  input wire logic vector_branch,
  input wire logic [13:0] vector_addr,
  input wire logic osc_driver_en,
  input wire logic io_hold,
  input wire logic sleeping,
  input wire logic powerdown_flag,
  input wire logic timeout_flag
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [11:0] slp_cnt_q; // cycles spent out of run
  logic xtal; // crystal oscillator mode selected
  logic pend; // enabled interrupt flagged
  assign xtal = configuration_word[2:0] <= swwc_pkg::FOSC_HS;
  assign pend = |(irq_enable & irq_flag);
  // count sleep cycles, saturating
  always_ff @(posedge clk) begin
    if (rst || !sleeping) begin
      slp_cnt_q <= 12'h000;
    end else if (slp_cnt_q != 12'hFFF) begin
      slp_cnt_q <= slp_cnt_q + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence s_go;
    sleep_instr && !sleeping && !pend;
  endsequence
  sequence s_nop;
    sleep_instr && !sleeping && pend;
  endsequence
  a_pin_released:
    assert property (master_clear_pin_oe_n) else $error("pin driven");
  a_sleep_entry:
    assert property (s_go |=> !powerdown_flag && timeout_flag && sleeping
      && prefetch_next) else $error("sleep entry wrong");
  a_sleep_nop:
    assert property (s_nop |=> !sleeping && prefetch_next
      && $stable(powerdown_flag) && $stable(timeout_flag))
    else $error("sleep not a no-op");
  a_asleep_hold:
    assert property ($rose(sleeping) |-> !osc_driver_en && io_hold)
    else $error("sleep state not held");
  a_fast_wake:
    assert property (s_go ##0 !xtal ##1 pend |-> ##[1:3] resume_exec)
    else $error("fast wake late");
  a_xtal_delay:
    assert property (resume_exec && xtal |-> slp_cnt_q >= 12'h400)
    else $error("start-up delay short");
  a_vector_jump:
    assert property (vector_branch |-> resume_exec
      && vector_addr == swwc_pkg::IRQ_VECTOR) else $error("bad vector");
  a_wdt_flag:
    assert property (device_reset && master_clear_pin_n_i
      && $past(master_clear_pin_n_i, 5) |-> ##[0:1] !timeout_flag)
    else $error("timeout flag kept");
  a_fuse_off:
    assert property (!configuration_word[3] && !$past(configuration_word[3])
      && !$past(configuration_word[3], 2) && master_clear_pin_n_i
      && $past(master_clear_pin_n_i, 5) |-> !device_reset)
    else $error("reset with fuse off");
endmodule : swwc_chk

bind swwc_top swwc_chk #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.*);

// ---- tb/swwc_irq_model.sv ----
// interrupt source model raising one flag after a chosen delay
module swwc_irq_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] src,
  input wire logic [7:0] dly,
  output logic [5:0] irq_flag
);
  logic [7:0] cnt_q; // cycles since fire rose
  always_ff @(posedge clk) begin
    if (!fire) begin
      cnt_q <= 8'h00;
      irq_flag <= 6'h00;
    end else if (cnt_q < dly) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      irq_flag[src] <= 1'b1;
    end
  end
endmodule : swwc_irq_model

// ---- tb/testbench.sv ----
// self-checking bench for the sleep, wake and watchdog controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDT = 64; // shortened watchdog count
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, sleep_instr, watchdog_clear_instr;
  logic global_irq_enable, osc_fail, master_clear_pin_n_i;
  logic master_clear_pin_o, master_clear_pin_oe_n, device_reset;
  logic prefetch_next, resume_exec, vector_branch, osc_driver_en, io_hold;
  logic sleeping, powerdown_flag, timeout_flag, fire, rst_d;
  logic [7:0] s_axi_awaddr, s_axi_araddr, configuration_word, dly;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] irq_enable, irq_flag;
  logic [13:0] vector_addr;
  logic [2:0] src;
  int n_mismatch, n_compared, seed, n_res, n_vec, n_rst, n_pre, b_res;
  int b_vec, b_rst, b_pre, exp_to, exp_pd, exp_cause, ps;

  swwc_top #(.WDT_CYCLES(WDT)) i_dut (.*);
  swwc_irq_model i_irq (.clk, .fire, .src, .dly, .irq_flag);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count pulses seen at the core side
  always @(posedge clk) begin
    rst_d <= device_reset;
    if (resume_exec === 1'b1) n_res++;
    if (vector_branch === 1'b1) n_vec++;
    if (device_reset === 1'b1 && rst_d !== 1'b1) n_rst++;
    if (prefetch_next === 1'b1) n_pre++;
  end
  // ----------------------------------------
  // model and checking tasks
  // ----------------------------------------
  function automatic logic [31:0] exp_stat(input int slp);
    return 32'((exp_cause << 4) | (slp << 2) | (exp_pd << 1) | exp_to);
  endfunction : exp_stat
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_cnt(input int got, input int exp);
    chk_word(32'(got), 32'(exp));
  endtask : chk_cnt
  task automatic snap;
    b_res = n_res;
    b_vec = n_vec;
    b_rst = n_rst;
    b_pre = n_pre;
  endtask : snap
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1'b1) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1'b1) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic sleep_go;
    snap();
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask : sleep_go
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, sleep_instr, watchdog_clear_instr, osc_fail} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dly} = 56'h0;
    {global_irq_enable, fire, src, irq_enable} = 11'h000;
    {n_res, n_vec, n_rst, n_pre, n_mismatch, n_compared} = '0;
    s_axi_wstrb = 4'hF;
    master_clear_pin_n_i = 1'b1;
    configuration_word = 8'h05;
    seed = 33;
    {exp_to, exp_pd, exp_cause} = {32'sd1, 32'sd1, 32'sd0};
    rst = 1'b1;
    idle(8);
    rst <= 1'b0;
    idle(2);
    // register map, reset values, fuse off
    axi_rd(swwc_pkg::ADDR_OPTION);
    chk_word(rd, 32'h0000_00FF);
    axi_rd(swwc_pkg::ADDR_STATUS);
    chk_word(rd, exp_stat(0));
    axi_rd(8'h0C);
    chk_word(32'(rsp), 32'(swwc_pkg::RESP_SLVERR));
    axi_wr(swwc_pkg::ADDR_CONFIG, 32'h0000_0000);
    axi_rd(swwc_pkg::ADDR_CONFIG);
    chk_word(rd, {24'h000000, configuration_word});
    rnd = $random(seed);
    axi_wr(swwc_pkg::ADDR_OPTION, rnd);
    axi_rd(swwc_pkg::ADDR_OPTION);
    chk_word(rd, {24'h000000, rnd[7:0]});
    idle(300);
    chk_cnt(n_rst, 0);
    // clears keep a short watchdog from expiring
    axi_wr(swwc_pkg::ADDR_OPTION, 32'h0000_0000);
    configuration_word <= 8'h0D;
    for (int i = 0; i < 10; i++) begin
      idle(40);
      watchdog_clear_instr <= i[0];
      osc_fail <= !i[0];
      idle(1);
      {watchdog_clear_instr, osc_fail} <= 2'b00;
    end
    chk_cnt(n_rst, 0);
    // prescaled expiry in run resets the device
    ps = $unsigned($random(seed)) % 4;
    axi_wr(swwc_pkg::ADDR_OPTION, 32'(8'h08 | ps));
    watchdog_clear_instr <= 1'b1;
    idle(1);
    watchdog_clear_instr <= 1'b0;
    idle(WDT * (1 << ps) - 8);
    chk_cnt(n_rst, 0);
    idle((1 << ps) + 24);
    chk_cnt(n_rst, 1);
    chk_word({30'h0, master_clear_pin_oe_n, master_clear_pin_o}, 32'h2);
    exp_to = 0;
    axi_rd(swwc_pkg::ADDR_STATUS);
    chk_word(rd & 32'h0F, exp_stat(0) & 32'h0F);
    axi_rd(swwc_pkg::ADDR_OPTION);
    chk_word(rd, 32'h0000_00FF);
    // pending enabled interrupt turns sleep into a no-op
    irq_enable <= 6'h3F;
    fire <= 1'b1;
    idle(3);
    sleep_go();
    idle(3);
    chk_word(32'(sleeping), 32'h0);
    chk_cnt(n_pre - b_pre, 1);
    axi_rd(swwc_pkg::ADDR_STATUS);
    chk_word(rd & 32'h0F, exp_stat(0) & 32'h0F);
    fire <= 1'b0;
    // interrupt wake, fast clock, both global enables
    for (int g = 0; g < 2; g++) begin
      global_irq_enable <= g[0];
      src <= 3'($unsigned($random(seed)) % 6);
      dly <= 8'(2 + g * 5);
      sleep_go();
      idle(2);
      chk_word({30'h0, osc_driver_en, io_hold}, 32'h1);
      {exp_to, exp_pd} = {32'sd1, 32'sd0};
      axi_rd(swwc_pkg::ADDR_STATUS);
      chk_word(rd, exp_stat(1));
      fire <= 1'b1;
      idle(16);
      chk_cnt(n_res - b_res, 1);
      chk_cnt(n_vec - b_vec, g);
      fire <= 1'b0;
      exp_cause = 3;
      axi_rd(swwc_pkg::ADDR_STATUS);
      chk_word(rd, exp_stat(0));
    end
    // disabled source stays asleep; watchdog wakes instead
    irq_enable <= 6'h01;
    src <= 3'h5;
    fire <= 1'b1;
    axi_wr(swwc_pkg::ADDR_OPTION, 32'h0000_0000);
    sleep_go();
    idle(30);
    chk_word(32'(sleeping), 32'h1);
    idle(WDT + 20);
    chk_cnt(n_res - b_res, 1);
    chk_cnt(n_vec - b_vec, 0);
    axi_wr(swwc_pkg::ADDR_OPTION, 32'h0000_00FF);
    {exp_to, exp_cause} = {32'sd0, 32'sd2};
    axi_rd(swwc_pkg::ADDR_STATUS);
    chk_word(rd, exp_stat(0));
    fire <= 1'b0;
    // crystal mode waits for the start-up timer
    configuration_word <= 8'h09;
    {irq_enable, src, dly} <= {6'h3F, 3'h0, 8'h00};
    global_irq_enable <= 1'b0;
    sleep_go();
    fire <= 1'b1;
    idle(1000);
    chk_cnt(n_res - b_res, 0);
    idle(100);
    chk_cnt(n_res - b_res, 1);
    fire <= 1'b0;
    // pin wake is a full reset
    configuration_word <= 8'h0D;
    irq_enable <= 6'h00;
    sleep_go();
    idle(4);
    master_clear_pin_n_i <= 1'b0;
    idle(10);
    chk_cnt(n_rst - b_rst, 1);
    chk_cnt(n_res - b_res, 0);
    master_clear_pin_n_i <= 1'b1;
    idle(8);
    {exp_to, exp_pd, exp_cause} = {32'sd1, 32'sd0, 32'sd1};
    axi_rd(swwc_pkg::ADDR_STATUS);
    chk_word(rd, exp_stat(0));
    // flag rising with the sleep strobe: sleep takes effect, wakes at once
    irq_enable <= 6'h3F;
    dly <= 8'h00;
    snap();
    @(posedge clk);
    sleep_instr <= 1'b1;
    fire <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    idle(8);
    chk_cnt(n_res - b_res, 1);
    chk_cnt(n_pre - b_pre, 1);
    chk_cnt(n_rst - b_rst, 0);
    fire <= 1'b0;
    exp_cause = 3;
    axi_rd(swwc_pkg::ADDR_STATUS);
    chk_word(rd, exp_stat(0));
    close_out();
  end
endmodule : testbench
